// ### rtl/rhat_access_targets.v
// Target selection and byte sequencing for host accesses.
// Assumes host strobes are synchronous to mclk and that an arbiter
// raises busGrant when the core is not using the data store.
`timescale 1ns/1ns
`include "rhat_map.vh"

module rhat_access_targets (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Host request
    input wire remoteSelectN,
    input wire hostReadStrobeN,
    input wire hostWriteStrobeN,
    input wire configSelect,
    // Arbitration and handshake
    input wire busGrant,
    input wire waitN,
    output reg busHandover,
    output reg transferAcknowledgeN,
    // Programmed wait states
    input wire [2:0] dataWaitStates,
    input wire [1:0] instrWaitStates,
    // Shared bus
    input wire [7:0] adIn,
    output reg [7:0] adOut,
    output reg adOe,
    output reg addrOe,
    // Data store strobes
    output reg memReadN,
    output reg memWriteN,
    // Instruction store
    input wire [15:0] instrReadData,
    output reg [15:0] instrWriteData,
    output reg instrWriteStrobeN,
    // State
    output reg [15:0] programCounter,
    output reg [7:0] interfaceConfigReg,
    output wire highByteNext
);

    // ****************************************
    // States
    // ****************************************
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ARB = 3'h1;
    localparam [2:0] ST_ACC1 = 3'h2;
    localparam [2:0] ST_ACC2 = 3'h3;
    localparam [2:0] ST_TERM = 3'h4;
    localparam [2:0] ST_DROP = 3'h5;
    localparam [2:0] ST_REL = 3'h6;

    // ****************************************
    // Declarations
    // ****************************************
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg cmd_q;
    reg write_q;
    reg hi_q;
    reg [1:0] target_q;
    reg [7:0] lowByteHolding_q;
    reg [7:0] adOut_d;
    reg adOe_d;
    reg [`RHAT_WAIT_W-1:0] waitLoad;
    wire request;
    wire waitsDone;
    wire termEntry;
    wire isData;
    wire isInstr;
    wire isCount;
    wire isConfigWrite;
    wire inHandover;
    wire inStrobe;

    // Selects the low or high half of a word
    function [7:0] pickByte;
        input [15:0] word;
        input hi;
        begin
            pickByte = hi ? word[15:8] : word[7:0];
        end
    endfunction

    // ****************************************
    // Request decode
    // ****************************************
    // Select gates either strobe; no ordering between them is assumed
    assign request = !remoteSelectN && (!hostReadStrobeN || !hostWriteStrobeN);

    // Attributes latched at request time, not live pins
    assign isData = !cmd_q && (target_q == `RHAT_TGT_DATA);
    assign isInstr = !cmd_q && (target_q == `RHAT_TGT_INSTR);
    assign isCount = !cmd_q && (target_q[1] == 1'b1);
    assign isConfigWrite = cmd_q && write_q;
    assign termEntry = (state_q == ST_ACC2) && (state_d == ST_TERM);
    assign inHandover = (state_d == ST_ACC1) || (state_d == ST_ACC2) || (state_d == ST_TERM);
    assign inStrobe = (state_d == ST_ACC2);

    // ****************************************
    // Sequencer
    // ****************************************
    // One step per T-state; access phase is ACC1 plus at least one ACC2
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (request) begin
                    state_d = ST_ARB;
                end
            end
            ST_ARB: begin
                if (busGrant) begin
                    state_d = ST_ACC1;
                end
            end
            ST_ACC1: begin
                state_d = ST_ACC2;
            end
            ST_ACC2: begin
                if (waitsDone && waitN) begin
                    state_d = ST_TERM;
                end
            end
            ST_TERM: begin
                state_d = ST_DROP;
            end
            ST_DROP: begin
                state_d = ST_REL;
            end
            ST_REL: begin
                // Strobes still low must not start a second access
                if (!request) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Per-access latches
    // ****************************************
    // Config-select and target are frozen for the whole access
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmd_q <= 1'b0;
            write_q <= 1'b0;
            hi_q <= 1'b0;
            target_q <= `RHAT_TGT_INSTR;
        end else if (state_q == ST_IDLE && request) begin
            cmd_q <= configSelect;
            write_q <= !hostWriteStrobeN;
            hi_q <= highByteNext;
            target_q <= interfaceConfigReg[`RHAT_SEL_MSB:`RHAT_SEL_LSB];
        end
    end

    // ****************************************
    // Wait states
    // ****************************************
    // Config and counter accesses take no programmed waits
    always @* begin
        if (isData) begin
            waitLoad = dataWaitStates;
        end else if (isInstr) begin
            waitLoad = {1'b0, instrWaitStates};
        end else begin
            waitLoad = {`RHAT_WAIT_W{1'b0}};
        end
    end

    rhat_wait_counter rhat_wait_counter_i (
        .mclk(mclk),
        .rstn(rstn),
        .load(state_q == ST_ACC1),
        .loadValue(waitLoad),
        .expired(waitsDone)
    );

    // ****************************************
    // Byte tracker
    // ****************************************
    rhat_byte_tracker rhat_byte_tracker_i (
        .mclk(mclk),
        .rstn(rstn),
        .toggle(termEntry && isInstr),
        .forceLow(termEntry && isConfigWrite &&
                  adIn[`RHAT_SEL_MSB:`RHAT_SEL_LSB] == `RHAT_TGT_INSTR),
        .highNext_q(highByteNext)
    );

    // ****************************************
    // Handshake outputs
    // ****************************************
    // Ack falls on request and rises as the access phase closes
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busHandover <= 1'b0;
            transferAcknowledgeN <= 1'b1;
        end else begin
            busHandover <= inHandover;
            transferAcknowledgeN <= !((state_d == ST_ARB) || (state_d == ST_ACC1) || (state_d == ST_ACC2));
        end
    end

    // ****************************************
    // Config register
    // ****************************************
    // Written only by the host; the core has no path to it
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            interfaceConfigReg <= `RHAT_CFG_RESET;
        end else if (termEntry && isConfigWrite) begin
            interfaceConfigReg <= adIn;
        end
    end

    // ****************************************
    // Program counter
    // ****************************************
    // Increment lands one T-state after handover drops
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            programCounter <= `RHAT_COUNT_RESET;
        end else if (termEntry && isCount && write_q) begin
            if (target_q == `RHAT_TGT_CNT_HI) begin
                programCounter <= {adIn, programCounter[7:0]};
            end else begin
                programCounter <= {programCounter[15:8], adIn};
            end
        end else if (state_q == ST_DROP && isInstr && hi_q) begin
            programCounter <= programCounter + 16'h0001;
        end
    end

    // ****************************************
    // Instruction write path
    // ****************************************
    // Low byte waits in the holding register for its partner
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lowByteHolding_q <= 8'h00;
        end else if (termEntry && isInstr && write_q && !hi_q) begin
            lowByteHolding_q <= adIn;
        end
    end

    // Word presented while the strobe is low on the high byte
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            instrWriteData <= 16'h0000;
            instrWriteStrobeN <= 1'b1;
        end else begin
            if (inHandover && isInstr && write_q && hi_q) begin
                instrWriteData <= {adIn, lowByteHolding_q};
            end
            instrWriteStrobeN <= !(inStrobe && isInstr && write_q && hi_q);
        end
    end

    // ****************************************
    // Data store strobes
    // ****************************************
    // Host owns address and data; the device only times the strobe
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            memReadN <= 1'b1;
            memWriteN <= 1'b1;
            addrOe <= 1'b1;
        end else begin
            memReadN <= !(inStrobe && isData && !write_q);
            memWriteN <= !(inStrobe && isData && write_q);
            addrOe <= !(inHandover && isData);
        end
    end

    // ****************************************
    // Shared bus drive
    // ****************************************
    // Config contents are the idle value, so a config read shows no change
    always @* begin
        adOut_d = interfaceConfigReg & `RHAT_CFG_RD_MASK;
        adOe_d = 1'b1;
        if (inHandover && !cmd_q) begin
            if (write_q || isData) begin
                adOe_d = 1'b0;
            end else if (state_d == ST_ACC1) begin
                adOe_d = 1'b0;
            end else if (isCount) begin
                adOut_d = pickByte(programCounter, target_q[0]);
            end else begin
                adOut_d = pickByte(instrReadData, hi_q);
            end
        end else if (inHandover && write_q) begin
            adOe_d = 1'b0;
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            adOut <= `RHAT_CFG_RESET & `RHAT_CFG_RD_MASK;
            adOe <= 1'b1;
        end else begin
            adOut <= adOut_d;
            adOe <= adOe_d;
        end
    end

endmodule // rhat_access_targets

// ### rtl/rhat_map.vh
// Constants for the remote host access targets block.
// Assumes one T-state equals one mclk period at 100 MHz.
//
// Contract
// - Config-select high routes a host access to the interface config register.
// - Config register reads and writes are accepted at any time; the sequencer still holds them in ST_ARB until busGrant.
// - Config register contents drive the shared bus by default.
// - Config write floats bus during handover, captures on ack rise, drives back.
// - Config access phase is two T-states; only low wait lengthens it.
// - Config-select low routes the access to the target-select field's target.
// - Target codes: 00 data store, 10 counter low byte, 11 counter high byte.
// - Data store access floats device address and data lines.
// - Data store read strobe lasts one T-state plus data waits and wait input.
// - Data store write strobe lasts one T-state plus waits and wait input.
// - Counter read byte valid one T-state after handover, before ack; two T-states.
// - Counter write keeps shared bus floated while handover is high.
// - Instruction words move low byte then high byte, reads alternate halves.
// - Instruction write low byte held in a holding register until high byte.
// - Counter increments one T-state after handover falls on high-byte access.
// - Byte tracker starts low, toggles per instruction access, else unchanged.
// - Writing 01 to target select or reset forces tracker to low byte.
// - Target select powers up as instruction store, serving repeated accesses.
// - Instruction read byte on bus one T-state after handover; waits extend it.
// - Instruction write handover at least three T-states; strobe on high byte.
// - Target select sits in the two low bits of the config register.
`ifndef RHAT_MAP_VH
`define RHAT_MAP_VH

// ****************************************
// Timing
// ****************************************
`define RHAT_CLK_PERIOD_NS 10
`define RHAT_TSTATE_NS 10
`define RHAT_TSTATE_CYC ((`RHAT_TSTATE_NS + `RHAT_CLK_PERIOD_NS - 1) / `RHAT_CLK_PERIOD_NS)

// ****************************************
// Config register layout
// ****************************************
`define RHAT_SEL_LSB 0
`define RHAT_SEL_MSB 1
`define RHAT_CFG_RESET 8'h01
`define RHAT_CFG_RD_MASK 8'hbf
`define RHAT_COUNT_RESET 16'h0000

// ****************************************
// Target codes
// ****************************************
`define RHAT_TGT_DATA 2'h0
`define RHAT_TGT_INSTR 2'h1
`define RHAT_TGT_CNT_LO 2'h2
`define RHAT_TGT_CNT_HI 2'h3

// ****************************************
// Wait counter width
// ****************************************
`define RHAT_WAIT_W 3

`endif

// ### rtl/rhat_byte_tracker.v
// Low/high byte tracker for instruction store accesses.
// Assumes toggle and forceLow are one-cycle pulses from the access sequencer.
`timescale 1ns/1ns

module rhat_byte_tracker (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Control
    input wire toggle,
    input wire forceLow,
    // State
    output reg highNext_q
);

    // Force wins over toggle so a realign never lands on the high half
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            highNext_q <= 1'b0;
        end else if (forceLow) begin
            highNext_q <= 1'b0;
        end else if (toggle) begin
            highNext_q <= ~highNext_q;
        end
    end

endmodule // rhat_byte_tracker

// ### rtl/rhat_wait_counter.v
// Down counter for programmed wait states in the access phase.
// Assumes load is asserted for one cycle before counting starts.
`timescale 1ns/1ns
`include "rhat_map.vh"

module rhat_wait_counter (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Control
    input wire load,
    input wire [`RHAT_WAIT_W-1:0] loadValue,
    // Status
    output wire expired
);

    reg [`RHAT_WAIT_W-1:0] count_q;

    // Programmed waits run out before the wait input is even looked at
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_q <= {`RHAT_WAIT_W{1'b0}};
        end else if (load) begin
            count_q <= loadValue;
        end else if (count_q != {`RHAT_WAIT_W{1'b0}}) begin
            count_q <= count_q - {{(`RHAT_WAIT_W-1){1'b0}}, 1'b1};
        end
    end

    assign expired = (count_q == {`RHAT_WAIT_W{1'b0}});

endmodule // rhat_wait_counter

// ### verif/rhat_access_targets_props.sv
// Port assertions for rhat_access_targets.
// Assumes a bind to the top module and one clock domain.
`timescale 1ns/1ns
`include "rhat_map.vh"

module rhat_access_targets_props (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Host request and wait input
    input wire configSelect,
    input wire hostWriteStrobeN,
    input wire waitN,
    // Device outputs
    input wire busHandover,
    input wire transferAcknowledgeN,
    input wire [7:0] adOut,
    input wire adOe,
    input wire addrOe,
    input wire memReadN,
    input wire memWriteN,
    input wire instrWriteStrobeN,
    input wire [15:0] programCounter,
    input wire [7:0] interfaceConfigReg,
    input wire highByteNext
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    reg cmdQ, wrQ, hiQ;
    reg [1:0] tgtQ;
    wire dat = !cmdQ && tgtQ == `RHAT_TGT_DATA;
    wire ins = !cmdQ && tgtQ == `RHAT_TGT_INSTR;
    wire pcx = !cmdQ && tgtQ[1];
    // Access kind, taken as ack falls while the host still holds its request
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {cmdQ, wrQ, hiQ, tgtQ} <= 5'h00;
        end else if ($fell(transferAcknowledgeN)) begin
            {cmdQ, wrQ, hiQ} <= {configSelect, !hostWriteStrobeN, $past(highByteNext)};
            tgtQ <= interfaceConfigReg[1:0];
        end
    end
    chk_cfg_default: assert property (!busHandover |-> adOe && adOut == (interfaceConfigReg & `RHAT_CFG_RD_MASK))
        else $error("config byte missing on idle bus");
    chk_bus_float: assert property (busHandover && wrQ |-> !adOe)
        else $error("bus driven during host write");
    chk_cfg_phase: assert property ($rose(busHandover) && cmdQ ##1 waitN
        |-> !transferAcknowledgeN ##1 transferAcknowledgeN) else $error("config phase not two cycles");
    chk_data_float: assert property (busHandover && dat |-> !adOe && !addrOe)
        else $error("lines driven in data access");
    chk_rd_strobe: assert property ($rose(busHandover) && dat && !wrQ |=> !memReadN)
        else $error("read strobe missing");
    chk_wr_strobe: assert property ($rose(busHandover) && dat && wrQ |=> !memWriteN)
        else $error("write strobe missing");
    chk_count_read: assert property ($rose(busHandover) && pcx && !wrQ
        |=> adOe && adOut == (tgtQ[0] ? programCounter[15:8] : programCounter[7:0])) else $error("counter byte wrong");
    chk_count_step: assert property ($fell(busHandover) && ins && hiQ
        |=> programCounter == $past(programCounter) + 16'h0001) else $error("counter not stepped");
    chk_track_flip: assert property ($fell(busHandover) && !cmdQ |=> highByteNext == (hiQ ^ ins))
        else $error("byte tracker wrong");
    chk_track_force: assert property ($fell(busHandover) && cmdQ && wrQ && interfaceConfigReg[1:0] == 2'h1
        |=> !highByteNext) else $error("tracker not forced low");
    chk_iwr_high: assert property (!instrWriteStrobeN |-> busHandover && ins && wrQ && hiQ)
        else $error("stray instruction strobe");
    chk_iwr_hold: assert property ($rose(busHandover) && ins && wrQ |-> busHandover [*3])
        else $error("handover too short");
endmodule // rhat_access_targets_props

// ### verif/rhat_host_model.sv
// Host processor model: select, strobes, config-select and write data.
// Assumes the device answers with ack low then high; resolves the shared bus.
`timescale 1ns/1ns

module rhat_host_model (
    // Clock
    input wire mclk,
    // Device answer
    input wire transferAcknowledgeN,
    input wire adOe,
    input wire [7:0] adOut,
    // Host request
    output reg remoteSelectN,
    output reg hostReadStrobeN,
    output reg hostWriteStrobeN,
    output reg configSelect,
    output wire [7:0] adIn
);
    reg hostDrv = 1'b0;
    reg [7:0] hostData = 8'h00;
    reg [7:0] lastBus = 8'h00;
    // No pull on the bus, so an undriven bus shows the inverse of its last level
    assign adIn = adOe ? adOut : (hostDrv ? hostData : ~lastBus);
    always @(posedge mclk) begin
        if (adOe || hostDrv) lastBus <= adIn;
    end
    initial begin
        {remoteSelectN, hostReadStrobeN, hostWriteStrobeN, configSelect} = 4'hf;
    end
    // One access: hold the request until ack is seen high, then release
    task access(input isWr, input cmd, input [7:0] wd, output [7:0] rd);
        integer n;
        begin
            n = 0;
            @(posedge mclk);
            configSelect <= cmd;
            remoteSelectN <= 1'b0;
            hostWriteStrobeN <= !isWr;
            hostReadStrobeN <= isWr;
            hostData <= wd;
            hostDrv <= isWr;
            do begin
                @(posedge mclk);
                n = n + 1;
            end while (transferAcknowledgeN !== 1'b0 && n < 50);
            do begin
                @(posedge mclk);
                n = n + 1;
            end while (transferAcknowledgeN !== 1'b1 && n < 500);
            rd = adIn;
            {remoteSelectN, hostReadStrobeN, hostWriteStrobeN} <= 3'h7;
            hostDrv <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
endmodule // rhat_host_model

// ### verif/test_rhat_access_targets.sv
// Self-checking bench for rhat_access_targets with random arbitration timing.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`include "rhat_map.vh"
`define CHK(a, b) begin nChecks = nChecks + 1; if ((a) !== (b)) begin failCount = failCount + 1; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

module test_rhat_access_targets;
    reg mclk, rstn, busGrant, waitN, waitRand;
    reg [2:0] dataWaitStates;
    reg [1:0] instrWaitStates;
    wire selN, rdN, wrN, cmd, busHandover, ackN, adOe, addrOe, memReadN, memWriteN, iwrN, highByteNext;
    wire [7:0] adIn, adOut, cfgReg;
    wire [15:0] iwData, progCnt, iData;
    integer seed, failCount, nChecks, cycles, rdLow, wrLow, iwCnt, c, k;
    reg [15:0] iwAddr, iwWord, pc0, w;
    reg [7:0] rd, v;
    // Instruction store contents depend on the address
    function [15:0] expWord(input [15:0] a);
        expWord = {a[7:0] ^ 8'h96, a[15:8] ^ a[7:0]};
    endfunction
    assign iData = expWord(progCnt);

    rhat_access_targets rhat_access_targets_i (.mclk(mclk), .rstn(rstn), .remoteSelectN(selN),
        .hostReadStrobeN(rdN), .hostWriteStrobeN(wrN), .configSelect(cmd), .busGrant(busGrant), .waitN(waitN),
        .busHandover(busHandover), .transferAcknowledgeN(ackN), .dataWaitStates(dataWaitStates),
        .instrWaitStates(instrWaitStates), .adIn(adIn), .adOut(adOut), .adOe(adOe), .addrOe(addrOe),
        .memReadN(memReadN), .memWriteN(memWriteN), .instrReadData(iData), .instrWriteData(iwData),
        .instrWriteStrobeN(iwrN), .programCounter(progCnt), .interfaceConfigReg(cfgReg),
        .highByteNext(highByteNext));
    rhat_host_model rhat_host_model_i (.mclk(mclk), .transferAcknowledgeN(ackN), .adOe(adOe), .adOut(adOut),
        .remoteSelectN(selN), .hostReadStrobeN(rdN), .hostWriteStrobeN(wrN), .configSelect(cmd), .adIn(adIn));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Random grant and wait, strobe monitors, hang limit
    always @(posedge mclk) begin
        busGrant <= $random(seed);
        waitN <= !waitRand || ($random(seed) & 3) != 0;
        cycles = cycles + 1;
        if (!memReadN) rdLow = rdLow + 1;
        if (!memWriteN) wrLow = wrLow + 1;
        if (!iwrN) begin
            iwCnt = iwCnt + 1;
            iwAddr = progCnt;
            iwWord = iwData;
        end
        if (cycles > 8000) begin
            failCount = failCount + 1;
            endOfTest;
        end
    end
    // Programmed waits change only between accesses
    task acc(input isWr, input cm, input [7:0] wd);
        begin
            dataWaitStates <= $random(seed);
            instrWaitStates <= $random(seed);
            rdLow = 0;
            wrLow = 0;
            rhat_host_model_i.access(isWr, cm, wd, rd);
        end
    endtask
    // Config writes select counter low then high byte ahead of each counter byte write
    task loadCounter(input [15:0] a);
        begin
            acc(1, 1, 8'h02);
            acc(1, 0, a[7:0]);
            acc(1, 1, 8'h03);
            acc(1, 0, a[15:8]);
        end
    endtask
    task endOfTest;
        begin
            if (failCount == 0 && nChecks > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask

    initial begin
        {seed, failCount, nChecks, cycles, rdLow, wrLow, iwCnt} = {32'd93, 192'd0};
        {rstn, busGrant, waitN, waitRand, dataWaitStates, instrWaitStates} = 9'h030;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        `CHK({cfgReg, progCnt, highByteNext}, {`RHAT_CFG_RESET, 17'h0})
        acc(0, 1, 8'h00);
        `CHK(rd, `RHAT_CFG_RESET & `RHAT_CFG_RD_MASK)
        for (k = 0; k < 6; k = k + 1) begin
            v = $random(seed);
            acc(1, 1, v);
            acc(0, 1, 8'h00);
            `CHK(rd, v & `RHAT_CFG_RD_MASK)
        end
        // Counter bytes written then read back through the select field
        pc0 = $random(seed);
        loadCounter(pc0);
        `CHK(progCnt, pc0)
        acc(1, 1, 8'h02);
        acc(0, 0, 8'h00);
        `CHK(rd, pc0[7:0])
        acc(1, 1, 8'h03);
        acc(0, 0, 8'h00);
        `CHK(rd, pc0[15:8])
        // Data store strobes with no wait input: one cycle plus programmed waits
        waitRand = 1'b0;
        acc(1, 1, 8'h00);
        for (k = 0; k < 4; k = k + 1) begin
            acc(k[0], 0, $random(seed));
            `CHK(rdLow + wrLow, 1 + dataWaitStates)
            `CHK(k[0] ? rdLow : wrLow, 0)
        end
        // Soft-load three words; wait input still high, so strobe length shows instruction waits
        loadCounter(pc0);
        acc(1, 1, 8'h01);
        for (k = 0; k < 3; k = k + 1) begin
            w = $random(seed);
            c = iwCnt;
            acc(1, 0, w[7:0]);
            `CHK(iwCnt, c)
            acc(1, 0, w[15:8]);
            `CHK({iwCnt != c, iwWord, iwAddr}, {1'b1, w, pc0 + k[15:0]})
            `CHK(iwCnt - c, 1 + instrWaitStates)
        end
        waitRand = 1'b1;
        `CHK(progCnt, pc0 + 16'h3)
        // Alternating reads, a config access between halves, then realignment
        loadCounter(pc0);
        acc(1, 1, 8'h01);
        for (k = 0; k < 5; k = k + 1) begin
            acc(0, 0, 8'h00);
            w = expWord(pc0 + k[15:1]);
            `CHK(rd, k[0] ? w[15:8] : w[7:0])
        end
        acc(0, 1, 8'h00);
        `CHK(highByteNext, 1'b1)
        acc(1, 1, 8'h01);
        `CHK(highByteNext, 1'b0)
        acc(0, 0, 8'h00);
        `CHK(rd, w[7:0])
        endOfTest;
    end
endmodule // test_rhat_access_targets

bind rhat_access_targets rhat_access_targets_props rhat_access_targets_props_i (.mclk(mclk), .rstn(rstn),
    .configSelect(configSelect), .hostWriteStrobeN(hostWriteStrobeN), .waitN(waitN), .busHandover(busHandover),
    .transferAcknowledgeN(transferAcknowledgeN), .adOut(adOut), .adOe(adOe), .addrOe(addrOe),
    .memReadN(memReadN), .memWriteN(memWriteN), .instrWriteStrobeN(instrWriteStrobeN),
    .programCounter(programCounter), .interfaceConfigReg(interfaceConfigReg), .highByteNext(highByteNext));
